// ==== src/slow_sleep_power_control.sv ====
// slow clock divider, pll lock sequencing, sleep entry and wake-up reset
// assumes an apb master on clk; crystal_input is a free-running clock enable pulse source
//
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/10ps
`include "slow_sleep_defines.svh"

// Operation
// (R1) slow mode divides the crystal or external clock, bypassing the pll
// (R2) slow divider codes 0..7 give divide by 1,2,4,6,8,10,12,14; usb clock unchanged
// (R3) bus clock is core or half; peripheral clock is bus or half
// (R4) main pll may be powered off while slow mode is on
// (R5) leaving slow mode with pll off inserts lock interval from lock register
// (R6) lock interval after pll power-on lasts 300 microseconds
// (R7) during lock interval the core clock stays the divided slow clock
// (R8) setting slow enable with pll on switches core clock to slow clock
// (R9) clearing slow enable after lock elapsed switches to pll at once
// (R10) clearing slow enable and pll off together switches after lock ends
// (R11) sleep removes core power; wake by external pins 15..0 or rtc alarm
// (R12) masked wake source still wakes but sets no pending bit
// (R13) software suspends usb pads before sleep
// (R14) software puts sdram in self-refresh before sleep
// (R15) software protects sdram clock pins before sleep
// (R16) software sets data bus pull-ups before sleep
// (R17) software masks interrupts, then sets sleep bit last
// (R18) general status bits 4:3 survive sleep
// (R19) wake-up asserts internal reset for 65535 crystal periods via 16-bit counter
// (R20) reset status bit 2 marks power-up from sleep wake-up
// (R21) software releases sdram protection after wake-up
// (R22) wake on pins 3:0 sets source pending; 15:4 only ext pending
// (R23) core power enable high keeps supplies on, low during sleep
// (R24) no wake-up while battery fault input is low
// (R25) core clock source switching is glitch-free
// (R26) wake reset counter counts from zero and releases at terminal value
module slow_sleep_power_control
	import slow_sleep_pkg::*;
#(
	parameter int unsigned LOCK_CYCLES = `LOCK_MIN_CYCLES
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic crystal_input,
	input wire logic pll_clock_tick,
	input wire logic [15:0] external_interrupt_pin,
	input wire logic rtc_alarm,
	input wire logic battery_fault_input_n,
	output logic core_clock,
	output logic hclk_tick,
	output logic pclk_tick,
	output logic core_clock_is_pll,
	output logic main_pll_power,
	output logic core_power_enable,
	output logic internal_reset_n
);
	// clocks are modelled as one-cycle ticks on clk so switching stays glitch-free
	logic [2:0] slow_divider_value_ff;
	logic slow_en_ff, main_pll_off_bit_ff;
	logic hclk_divider_select_ff, pclk_divider_select_ff;
	logic [15:0] lock_time_ff;
	logic [1:0] general_status_ff;
	logic reset_wake_ff;
	logic [15:0] wake_mask_ff, source_pend_ff, ext_pend_ff;
	logic [31:0] lock_cnt_ff;
	logic [15:0] wake_cnt_ff;
	logic [3:0] div_cnt_ff;
	logic hdiv_ff, pdiv_ff;
	logic use_pll_ff;
	logic power_on_ff, core_reset_n_ff;
	pm_state_t state_ff;
	logic wr, slow_tick, core_tick, wake_event;
	logic [15:0] pend_set, pend_clr, nxt_source_pend, nxt_ext_pend;
	logic [3:0] div_n;
	logic [31:0] lock_target;

	assign wr = psel & penable & pwrite;
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	// wake only while battery is healthy
	assign wake_event = (|external_interrupt_pin | rtc_alarm) & battery_fault_input_n; // (R11) (R24)

	always_comb begin
		unique case (slow_divider_value_ff) // (R2)
			3'h0: div_n = 4'h1;
			3'h1: div_n = 4'h2;
			3'h2: div_n = 4'h4;
			3'h3: div_n = 4'h6;
			3'h4: div_n = 4'h8;
			3'h5: div_n = 4'ha;
			3'h6: div_n = 4'hc;
			3'h7: div_n = 4'he;
		endcase
	end

	// slow clock: divide crystal ticks directly, pll not involved
	// a new code applies from the next slow tick at the latest; one period may be short
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			div_cnt_ff <= 4'h0;
		end else if (crystal_input) begin
			if (div_cnt_ff >= div_n - 4'h1) begin
				div_cnt_ff <= 4'h0;
			end else begin
				div_cnt_ff <= div_cnt_ff + 4'h1;
			end
		end
	end
	assign slow_tick = crystal_input && (div_cnt_ff >= div_n - 4'h1); // (R1)

	// whole ticks only from either source, so no shortened pulse
	assign core_tick = use_pll_ff ? pll_clock_tick : slow_tick; // (R25)
	assign core_clock = core_tick;
	assign core_clock_is_pll = use_pll_ff;
	assign main_pll_power = ~main_pll_off_bit_ff; // (R4)

	// bus dividers run free, so a ratio change may shorten one bus period
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			hdiv_ff <= 1'b0;
			pdiv_ff <= 1'b0;
		end else begin
			if (core_tick) begin
				hdiv_ff <= ~hdiv_ff;
			end
			if (hclk_tick) begin
				pdiv_ff <= ~pdiv_ff;
			end
		end
	end
	assign hclk_tick = core_tick & (~hclk_divider_select_ff | hdiv_ff); // (R3)
	assign pclk_tick = hclk_tick & (~pclk_divider_select_ff | pdiv_ff); // (R3)

	// the longer of the fixed floor and the software count, so a small count cannot cut the lock
	assign lock_target = LOCK_CYCLES > 32'(lock_time_ff) ? LOCK_CYCLES : 32'(lock_time_ff); // (R6)

	// register writes
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			slow_divider_value_ff <= 3'h0;
			slow_en_ff <= 1'b0;
			main_pll_off_bit_ff <= 1'b0;
			hclk_divider_select_ff <= 1'b0;
			pclk_divider_select_ff <= 1'b0;
			lock_time_ff <= `LOCK_TIME_RESET;
			wake_mask_ff <= 16'h0000;
		end else if (wr) begin
			unique case (paddr)
				`OFF_SLOW_CLOCK: begin
					slow_divider_value_ff <= pwdata[`SLOW_DIV_LSB +: 3];
					slow_en_ff <= pwdata[`SLOW_EN_BIT];
					// pll may only be off while slow mode is on
					main_pll_off_bit_ff <= pwdata[`PLL_OFF_BIT] & pwdata[`SLOW_EN_BIT]; // (R4)
				end
				`OFF_CLOCK_RATIO: begin
					hclk_divider_select_ff <= pwdata[`HCLK_SEL_BIT];
					pclk_divider_select_ff <= pwdata[`PCLK_SEL_BIT];
				end
				`OFF_LOCK_TIME: lock_time_ff <= pwdata[15:0];
				`OFF_WAKE_MASK: wake_mask_ff <= pwdata[15:0];
				default: ;
			endcase
		end
	end

	// general status held in the always-on domain: not cleared by wake reset
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			general_status_ff <= 2'h0;
		end else if (wr && paddr == `OFF_GENERAL_STATUS) begin
			general_status_ff <= pwdata[`GEN_STATUS_LSB +: 2]; // (R18)
		end
	end

	// power state sequencing
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_ff <= pm_normal;
			use_pll_ff <= 1'b0;
			lock_cnt_ff <= 32'h0;
			wake_cnt_ff <= 16'h0000;
			power_on_ff <= 1'b1;
			core_reset_n_ff <= 1'b1;
		end else begin
			unique case (state_ff)
				pm_normal: begin
					if (wr && paddr == `OFF_CLOCK_GATE && pwdata[`SLEEP_BIT]) begin
						state_ff <= pm_sleep;
						power_on_ff <= 1'b0; // (R11)
						core_reset_n_ff <= 1'b0;
					end else if (wr && paddr == `OFF_SLOW_CLOCK) begin
						if (pwdata[`SLOW_EN_BIT]) begin
							use_pll_ff <= 1'b0; // (R8)
						end else if (main_pll_off_bit_ff) begin
							// pll was off: stay on slow clock through lock
							lock_cnt_ff <= 32'h0;
							state_ff <= pm_lock; // (R5) (R10)
						end else begin
							use_pll_ff <= 1'b1; // (R9)
						end
					end
				end
				pm_lock: begin
					use_pll_ff <= 1'b0; // (R7)
					if (lock_cnt_ff >= lock_target - 32'h1) begin
						// a slow-enable write landing on the last lock cycle must still win
						use_pll_ff <= ~slow_en_ff
							& ~(wr && paddr == `OFF_SLOW_CLOCK && pwdata[`SLOW_EN_BIT]); // (R8)
						state_ff <= pm_normal; // (R10)
					end else begin
						lock_cnt_ff <= lock_cnt_ff + 32'h1;
					end
				end
				pm_sleep: begin
					use_pll_ff <= 1'b0;
					if (wake_event) begin
						wake_cnt_ff <= 16'h0000; // (R26)
						state_ff <= pm_wake_reset; // (R19)
						power_on_ff <= 1'b1; // (R23)
					end
				end
				// fixed length: with the crystal stopped the core stays in reset
				pm_wake_reset: begin
					if (crystal_input) begin
						if (wake_cnt_ff == `WAKE_RESET_COUNT - 16'h1) begin
							state_ff <= pm_normal; // (R26)
							core_reset_n_ff <= 1'b1; // (R19)
						end else begin
							wake_cnt_ff <= wake_cnt_ff + 16'h1; // (R19)
						end
					end
				end
			endcase
		end
	end

	// straight from flip-flops: decoding the state here could glitch the regulator enable
	assign core_power_enable = power_on_ff; // (R23)
	assign internal_reset_n = core_reset_n_ff; // (R19)

	// per pin: an unmasked wake sets the bit, writing 1 clears it, and a set wins a tie;
	// masked pins still wake the core but leave no trace here
	for (genvar i = 0; i < 16; i++) begin : g_pend
		assign pend_set[i] = (state_ff == pm_sleep) && wake_event
			&& external_interrupt_pin[i] && !wake_mask_ff[i]; // (R12)
		if (i < 4) begin : g_src
			assign pend_clr[i] = wr && (paddr == `OFF_SOURCE_PEND) && pwdata[i];
			assign nxt_source_pend[i] = pend_set[i] | (source_pend_ff[i] & ~pend_clr[i]); // (R22)
			assign nxt_ext_pend[i] = 1'b0;
		end else begin : g_ext
			assign pend_clr[i] = wr && (paddr == `OFF_EXT_PEND) && pwdata[i];
			assign nxt_ext_pend[i] = pend_set[i] | (ext_pend_ff[i] & ~pend_clr[i]); // (R22)
			assign nxt_source_pend[i] = 1'b0;
		end
	end

	// pending and reset-status flags: hardware set wins over software clear
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			source_pend_ff <= 16'h0000;
			ext_pend_ff <= 16'h0000;
			reset_wake_ff <= 1'b0;
		end else begin
			source_pend_ff <= nxt_source_pend;
			ext_pend_ff <= nxt_ext_pend;
			if (wr && paddr == `OFF_RESET_STATUS && pwdata[`RST_WAKE_BIT]) begin
				reset_wake_ff <= 1'b0;
			end
			if (state_ff == pm_sleep && wake_event) begin
				reset_wake_ff <= 1'b1; // (R20)
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			prdata <= 32'h0;
		end else if (psel && !penable && !pwrite) begin
			unique case (paddr)
				`OFF_SLOW_CLOCK: prdata <= {26'h0, main_pll_off_bit_ff, slow_en_ff, 1'b0,
					slow_divider_value_ff};
				`OFF_CLOCK_RATIO: prdata <= {30'h0, hclk_divider_select_ff,
					pclk_divider_select_ff};
				`OFF_CLOCK_GATE: prdata <= {28'h0, state_ff == pm_sleep, 2'h0,
					use_pll_ff};
				`OFF_LOCK_TIME: prdata <= {16'h0, lock_time_ff};
				`OFF_GENERAL_STATUS: prdata <= {27'h0, general_status_ff, 3'h0};
				`OFF_RESET_STATUS: prdata <= {29'h0, reset_wake_ff, 2'h0};
				`OFF_WAKE_MASK: prdata <= {16'h0, wake_mask_ff};
				`OFF_SOURCE_PEND: prdata <= {16'h0, source_pend_ff};
				`OFF_EXT_PEND: prdata <= {16'h0, ext_pend_ff};
				default: prdata <= 32'h0;
			endcase
		end
	end
endmodule

// ==== src/slow_sleep_defines.svh ====
// constants for the slow/sleep power control block
// assumes a 25 MHz system clock; included by bare name
`ifndef SLOW_SLEEP_DEFINES_SVH
`define SLOW_SLEEP_DEFINES_SVH
`define OFF_SLOW_CLOCK 8'h00
`define OFF_CLOCK_RATIO 8'h04
`define OFF_CLOCK_GATE 8'h08
`define OFF_LOCK_TIME 8'h0c
`define OFF_GENERAL_STATUS 8'h10
`define OFF_RESET_STATUS 8'h14
`define OFF_WAKE_MASK 8'h18
`define OFF_SOURCE_PEND 8'h1c
`define OFF_EXT_PEND 8'h20
`define SLOW_DIV_LSB 0
`define SLOW_EN_BIT 4
`define PLL_OFF_BIT 5
`define PCLK_SEL_BIT 0
`define HCLK_SEL_BIT 1
`define SLEEP_BIT 3
`define RST_WAKE_BIT 2
`define GEN_STATUS_LSB 3
`define LOCK_TIME_RESET 16'hffff
`define LOCK_TIME_US 300
`define CLK_MHZ 25
`define LOCK_MIN_CYCLES ((`LOCK_TIME_US) * (`CLK_MHZ))
`define WAKE_RESET_COUNT 16'hffff
`endif

// ==== src/slow_sleep_pkg.sv ====
// types for the slow/sleep power control block
// no assumptions beyond the defines header
package slow_sleep_pkg;
	typedef enum logic [1:0] {
		pm_normal,
		pm_lock,
		pm_sleep,
		pm_wake_reset
	} pm_state_t;
endpackage

// ==== verification/slow_sleep_monitor.sv ====
// port assertions for the slow/sleep power control block
// bound into every instance; one clock domain, async active-low reset
`timescale 1ns/10ps
`include "slow_sleep_defines.svh"
module slow_sleep_monitor (
	input wire logic clk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic crystal_input,
	input wire logic [15:0] external_interrupt_pin,
	input wire logic rtc_alarm,
	input wire logic battery_fault_input_n,
	input wire logic core_clock,
	input wire logic hclk_tick,
	input wire logic pclk_tick,
	input wire logic core_clock_is_pll,
	input wire logic main_pll_power,
	input wire logic core_power_enable,
	input wire logic internal_reset_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence s_wr(logic [7:0] a);
		psel && penable && pwrite && paddr == a;
	endsequence
	sequence s_wake;
		!core_power_enable && battery_fault_input_n && (|external_interrupt_pin || rtc_alarm);
	endsequence
	a_sleep_cuts_power: assert property (s_wr(`OFF_CLOCK_GATE) ##0 pwdata[3] |=> !core_power_enable)
		else $error("power enable high after sleep write");
	a_fault_blocks_wake: assert property (!core_power_enable && !battery_fault_input_n |=> !core_power_enable)
		else $error("woke during battery fault");
	a_wake_holds_reset: assert property (s_wake |=> (core_power_enable && !internal_reset_n) [*8])
		else $error("wake reset missing");
	a_slow_entry: assert property (s_wr(`OFF_SLOW_CLOCK) ##0 pwdata[4] |=> !core_clock_is_pll)
		else $error("pll still selected in slow mode");
	a_pll_power_off: assert property (s_wr(`OFF_SLOW_CLOCK) ##0 (pwdata[5] && pwdata[4]) |=> !main_pll_power)
		else $error("pll still powered");
	// needs a lock count of at least four cycles, which the fixed floor gives
	a_lock_keeps_slow: assert property (s_wr(`OFF_SLOW_CLOCK) ##0 (!pwdata[4] && !main_pll_power)
		|=> !core_clock_is_pll [*4])
		else $error("pll selected during lock");
	a_fast_exit: assert property (s_wr(`OFF_SLOW_CLOCK) ##0 (!pwdata[4] && main_pll_power) |=> core_clock_is_pll)
		else $error("pll not selected after slow exit");
	a_slow_from_xtal: assert property (!core_clock_is_pll && !crystal_input |-> !core_clock)
		else $error("slow clock tick without crystal tick");
	a_bus_ratio: assert property ((hclk_tick || pclk_tick) |-> core_clock && (hclk_tick || !pclk_tick))
		else $error("bus tick without parent tick");
endmodule
bind slow_sleep_power_control slow_sleep_monitor mon (.clk, .resetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .crystal_input, .external_interrupt_pin, .rtc_alarm, .battery_fault_input_n,
	.core_clock, .hclk_tick, .pclk_tick, .core_clock_is_pll, .main_pll_power, .core_power_enable,
	.internal_reset_n);

// ==== verification/slow_sleep_partner.sv ====
// far-side clock sources: crystal tick and pll output tick
// crystal ticks every clk, or every second clk when xtal_half is set
`timescale 1ns/10ps
module slow_sleep_partner (
	input wire logic clk,
	input wire logic xtal_half,
	output logic crystal_input,
	output logic pll_clock_tick
);
	logic [1:0] cnt_ff = 2'h0;
	always_ff @(posedge clk) begin
		cnt_ff <= cnt_ff + 2'h1;
	end
	// pll ticks at a quarter of clk so its pulses differ from the crystal path
	assign pll_clock_tick = cnt_ff == 2'h0;
	assign crystal_input = !xtal_half || cnt_ff[0];
endmodule

// ==== verification/tb_slow_sleep_power_control.sv ====
// self-checking bench for the slow/sleep power control block
// apb master tasks; lock count shortened to 8 cycles
`timescale 1ns/10ps
`include "slow_sleep_defines.svh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_fail++; \
	$display("Error %0t %h %h", $time, (a), (e)); end end
module tb_slow_sleep_power_control;
	logic clk = 1'h0, resetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [7:0] paddr = 8'h0;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic [15:0] external_interrupt_pin = 16'h0;
	logic rtc_alarm = 1'h0, battery_fault_input_n = 1'h1, xtal_half = 1'h0;
	logic pready, pslverr, crystal_input, pll_clock_tick, core_clock, hclk_tick, pclk_tick;
	logic core_clock_is_pll, main_pll_power, core_power_enable, internal_reset_n;
	logic err;
	int n_fail = 0, check_count = 0, cyc = 0, n, nc, nh, np, dv;
	slow_sleep_power_control #(.LOCK_CYCLES(8)) uut (.clk, .resetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .crystal_input, .pll_clock_tick,
		.external_interrupt_pin, .rtc_alarm, .battery_fault_input_n, .core_clock, .hclk_tick,
		.pclk_tick, .core_clock_is_pll, .main_pll_power, .core_power_enable, .internal_reset_n);
	slow_sleep_partner far (.clk, .xtal_half, .crystal_input, .pll_clock_tick);
	initial forever #20 clk = ~clk;
	task automatic end_of_test;
		if (n_fail == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 95000) begin
			n_fail++;
			end_of_test();
		end
	end
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		@(posedge clk);
		while (pready !== 1'h1) @(posedge clk);
		q = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		xfer(1'h0, a, 32'h0);
		`CHK({err, q}, {1'h0, e})
	endtask
	// counts ticks over 1680 clk, a multiple of every divided period
	task automatic cnt;
		nc = 0;
		nh = 0;
		np = 0;
		repeat (1680) begin
			@(negedge clk);
			nc += core_clock;
			nh += hclk_tick;
			np += pclk_tick;
		end
		@(posedge clk);
	endtask
	initial begin
		repeat (4) @(posedge clk);
		resetn <= 1'h1;
		@(posedge clk);
		`CHK(core_power_enable, 1'h1)
		rd(`OFF_LOCK_TIME, {16'h0, `LOCK_TIME_RESET});
		rd(8'h40, 32'h0);
		xfer(1'h1, `OFF_SLOW_CLOCK, 32'h0);
		`CHK(core_clock_is_pll, 1'h1)
		xtal_half <= 1'h1;
		for (int c = 0; c < 8; c++) begin
			xfer(1'h1, `OFF_CLOCK_RATIO, c % 4);
			xfer(1'h1, `OFF_SLOW_CLOCK, 32'h10 | c);
			`CHK(core_clock_is_pll, 1'h0)
			repeat (40) @(posedge clk);
			cnt();
			dv = (c == 0) ? 1 : 2 * c;
			`CHK(nc, 840 / dv)
			dv = dv * (c[1] ? 2 : 1);
			`CHK(nh, 840 / dv)
			`CHK(np, 840 / dv / (c[0] ? 2 : 1))
		end
		xtal_half <= 1'h0;
		xfer(1'h1, `OFF_LOCK_TIME, 32'h4);
		xfer(1'h1, `OFF_SLOW_CLOCK, 32'h30);
		`CHK(main_pll_power, 1'h0)
		xfer(1'h1, `OFF_SLOW_CLOCK, 32'h0);
		`CHK(core_clock_is_pll, 1'h0)
		n = 1;
		while (core_clock_is_pll !== 1'h1 && n < 99) begin
			@(posedge clk);
			n++;
		end
		`CHK(n >= 7 && n <= 10, 1'h1)
		xfer(1'h1, `OFF_GENERAL_STATUS, 32'h18);
		// usb pads, sdram and bus pull-ups sit outside this block
		xfer(1'h1, `OFF_WAKE_MASK, 32'h2);
		xfer(1'h1, `OFF_CLOCK_GATE, 32'h8);
		`CHK(core_power_enable, 1'h0)
		battery_fault_input_n <= 1'h0;
		external_interrupt_pin <= 16'h0026;
		rtc_alarm <= 1'h1;
		repeat (6) @(posedge clk);
		`CHK(core_power_enable, 1'h0)
		battery_fault_input_n <= 1'h1;
		repeat (3) @(posedge clk);
		external_interrupt_pin <= 16'h0;
		rtc_alarm <= 1'h0;
		`CHK(core_power_enable, 1'h1)
		n = 2;
		while (internal_reset_n !== 1'h1 && n < 70000) begin
			@(posedge clk);
			n++;
		end
		`CHK(n >= 65533 && n <= 65539, 1'h1)
		// releasing sdram protection is software work outside this block
		rd(`OFF_GENERAL_STATUS, 32'h18);
		rd(`OFF_RESET_STATUS, 32'h4);
		rd(`OFF_SOURCE_PEND, 32'h4);
		rd(`OFF_EXT_PEND, 32'h20);
		end_of_test();
	end
endmodule
